// ### rtl/ltt_pkg.sv
/*
 * Package for the line transceiver trim register bank: register byte
 * addresses, field positions, reset values and widths.
 * Assumes a 32-bit AHB-Lite bus with one word per register.
 */
package ltt_pkg;
    // register byte addresses
    localparam logic [7:0] LTT_ADDR_CMP0_TRIM = 8'h00;
    localparam logic [7:0] LTT_ADDR_CMP1_TRIM = 8'h04;
    localparam logic [7:0] LTT_ADDR_CMP_POLHY = 8'h08;
    localparam logic [7:0] LTT_ADDR_AMP_CTRL  = 8'h0c;
    localparam logic [7:0] LTT_ADDR_AMP_TRIM  = 8'h10;
    localparam int         LTT_ADDR_W         = 8;

    // comparator trim register fields
    localparam int LTT_CMP_MODE_BIT = 6;
    localparam int LTT_CMP_REF_BIT  = 5;
    localparam int LTT_CMP_TRIM_W   = 5;
    localparam logic [4:0] LTT_CMP_TRIM_RST = 5'h10;

    // polarity / hysteresis register fields
    localparam int LTT_OSEL_BIT    = 6;
    localparam int LTT_C1_INV_BIT  = 5;
    localparam int LTT_C0_INV_BIT  = 4;
    localparam int LTT_C1_HYS_LSB  = 2;
    localparam int LTT_C0_HYS_LSB  = 0;
    localparam int LTT_HYS_W       = 2;

    // amplifier control fields
    localparam int LTT_AMP_EN_BIT  = 6;
    localparam int LTT_AMP_OUT_BIT = 5;
    localparam int LTT_AMP_BW_BIT  = 0;

    // amplifier trim fields
    localparam int LTT_AMP_MODE_BIT = 7;
    localparam int LTT_AMP_REF_BIT  = 6;
    localparam int LTT_AMP_TRIM_W   = 6;
    localparam logic [5:0] LTT_AMP_TRIM_RST = 6'h20;

    // ahb constants
    localparam logic [1:0] LTT_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] LTT_HTRANS_SEQ    = 2'b11;
    localparam logic       LTT_HRESP_OKAY    = 1'b0;
endpackage

// ### rtl/ltt_result_path.sv
/*
 * Comparator result conditioning: per-comparator polarity and shared
 * output select, all registered.
 * Assumes raw comparator results synchronous to mclk.
 */
module ltt_result_path (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // raw results and controls
    input  wire logic cmp0Raw,
    input  wire logic cmp1Raw,
    input  wire logic cmp0Invert,
    input  wire logic cmp1Invert,
    input  wire logic cmpOutputSelect,
    // conditioned results
    output logic      cmp0Result,
    output logic      cmp1Result,
    output logic      cmpSelected
);
    logic c0_d, c1_d, sel_d;
    logic c0_q, c1_q, sel_q;

    always_comb begin
        c0_d  = cmp0Raw ^ cmp0Invert;
        c1_d  = cmp1Raw ^ cmp1Invert;
        sel_d = cmpOutputSelect ? c1_d : c0_d;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            c0_q  <= 1'b0;
            c1_q  <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            c0_q  <= c0_d;
            c1_q  <= c1_d;
            sel_q <= sel_d;
        end
    end

    assign cmp0Result  = c0_q;
    assign cmp1Result  = c1_q;
    assign cmpSelected = sel_q;

    a_sel_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        cmpSelected == $past(cmpOutputSelect ? (cmp1Raw ^ cmp1Invert)
                                             : (cmp0Raw ^ cmp0Invert)))
        else $error("selected output mismatch");
    a_cmp1_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
        $past(cmp1Invert) |-> cmp1Result == !$past(cmp1Raw))
        else $error("cmp1 polarity wrong");
    a_cmp0_polarity: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(cmp0Invert) |-> cmp0Result == $past(cmp0Raw))
        else $error("cmp0 polarity wrong");
endmodule

// ### rtl/ltt_trim_regs.sv
/*
 * Trim and control register bank for the transceiver analog front end:
 * two comparators and one amplifier, reached over AHB-Lite.
 * Assumes a single AHB-Lite master, word transfers, mclk at 100 MHz,
 * analog status inputs already synchronous to mclk.
 */
// Summary of operation
// - Bit 6 of each comparator trim register puts that comparator in offset calibration.
// - Comparator 1 reference bit 5 picks negative input at 0, positive input at 1.
// - Bits 4..0 of each comparator trim hold a 5-bit trim reset to 10000 driving the analog.
// - The stored trim written by software is applied to the analog in normal operation too.
// - Polarity register bit 6 forwards comparator 0 at 0 and comparator 1 at 1.
// - Polarity bit 5 inverts comparator 1's result when set.
// - Polarity bit 4 inverts comparator 0's result when set.
// - Two-bit hysteresis fields, reset zero: comparator 1 bits 3..2, comparator 0 bits 1..0.
// - Amplifier trim bit 7 puts the amplifier in offset calibration.
// - Amplifier reference bit 6 picks negative input at 0, positive input at 1.
// - Amplifier trim bits 5..0 hold a 6-bit trim reset to 100000 driving the analog.
// - Bit 7 of the comparator trims and polarity register ignores writes and reads zero.
module ltt_trim_regs
    import ltt_pkg::*;
(
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    // ahb-lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    // analog status
    input  wire logic                         cmp0Raw,
    input  wire logic                         cmp1Raw,
    input  wire logic                         ampOutRaw,
    // comparator 0 controls
    output logic                              cmp0CalMode,
    output logic                              cmp0CalRefSel,
    output logic      [ltt_pkg::LTT_CMP_TRIM_W-1:0] cmp0OffsetTrim,
    output logic      [ltt_pkg::LTT_HYS_W-1:0]      cmp0Hysteresis,
    output logic                              cmp0Result,
    // comparator 1 controls
    output logic                              cmp1CalMode,
    output logic                              cmp1CalRefSel,
    output logic      [ltt_pkg::LTT_CMP_TRIM_W-1:0] cmp1OffsetTrim,
    output logic      [ltt_pkg::LTT_HYS_W-1:0]      cmp1Hysteresis,
    output logic                              cmp1Result,
    // shared comparator output
    output logic                              cmpSelected,
    // amplifier controls
    output logic                              ampEnable,
    output logic                              ampBandwidthSel,
    output logic                              ampCalMode,
    output logic                              ampCalRefSel,
    output logic      [ltt_pkg::LTT_AMP_TRIM_W-1:0] ampOffsetTrim
);
    import ltt_pkg::*;

    // register state
    logic [6:0] cmp0Trim_q, cmp0Trim_d;
    logic [6:0] cmp1Trim_q, cmp1Trim_d;
    logic [6:0] polHys_q,   polHys_d;
    logic       ampEn_q,    ampEn_d;
    logic       ampBw_q,    ampBw_d;
    logic [7:0] ampTrim_q,  ampTrim_d;
    logic       ampOut_q,   ampOut_d;

    // bus phase state
    logic                  wrPend_q, wrPend_d;
    logic [LTT_ADDR_W-1:0] addr_q,   addr_d;
    logic [31:0]           rdata_q,  rdata_d;
    logic                  cmp0Res, cmp1Res;

    function automatic logic [31:0] readMux(input logic [LTT_ADDR_W-1:0] a);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            LTT_ADDR_CMP0_TRIM: r = {25'h0, cmp0Trim_q};
            LTT_ADDR_CMP1_TRIM: r = {25'h0, cmp1Trim_q};
            LTT_ADDR_CMP_POLHY: r = {25'h0, polHys_q};
            LTT_ADDR_AMP_CTRL: begin
                r[LTT_AMP_EN_BIT]  = ampEn_q;
                r[LTT_AMP_OUT_BIT] = ampOut_q;
                r[LTT_AMP_BW_BIT]  = ampBw_q;
            end
            LTT_ADDR_AMP_TRIM:  r = {24'h0, ampTrim_q};
            default:            r = 32'h0;
        endcase
        return r;
    endfunction

    logic addrPhase;
    assign addrPhase = hsel && hready && htrans[1];

    always_comb begin
        wrPend_d   = addrPhase && hwrite;
        addr_d     = addrPhase ? haddr[LTT_ADDR_W-1:0] : addr_q;
        rdata_d    = (addrPhase && !hwrite) ? readMux(haddr[LTT_ADDR_W-1:0]) : rdata_q;
        cmp0Trim_d = cmp0Trim_q;
        cmp1Trim_d = cmp1Trim_q;
        polHys_d   = polHys_q;
        ampEn_d    = ampEn_q;
        ampBw_d    = ampBw_q;
        ampTrim_d  = ampTrim_q;
        ampOut_d   = ampOutRaw;
        if (wrPend_q) begin
            case (addr_q)
                LTT_ADDR_CMP0_TRIM: cmp0Trim_d = hwdata[6:0];
                LTT_ADDR_CMP1_TRIM: cmp1Trim_d = hwdata[6:0];
                LTT_ADDR_CMP_POLHY: polHys_d   = hwdata[6:0];
                LTT_ADDR_AMP_CTRL: begin
                    ampEn_d = hwdata[LTT_AMP_EN_BIT];
                    ampBw_d = hwdata[LTT_AMP_BW_BIT];
                end
                LTT_ADDR_AMP_TRIM:  ampTrim_d  = hwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp0Trim_q <= {2'b00, LTT_CMP_TRIM_RST};
            cmp1Trim_q <= {2'b00, LTT_CMP_TRIM_RST};
            polHys_q   <= 7'h00;
            ampEn_q    <= 1'b0;
            ampBw_q    <= 1'b0;
            ampTrim_q  <= {2'b00, LTT_AMP_TRIM_RST};
            ampOut_q   <= 1'b0;
            wrPend_q   <= 1'b0;
            addr_q     <= '0;
            rdata_q    <= 32'h0;
        end else begin
            cmp0Trim_q <= cmp0Trim_d;
            cmp1Trim_q <= cmp1Trim_d;
            polHys_q   <= polHys_d;
            ampEn_q    <= ampEn_d;
            ampBw_q    <= ampBw_d;
            ampTrim_q  <= ampTrim_d;
            ampOut_q   <= ampOut_d;
            wrPend_q   <= wrPend_d;
            addr_q     <= addr_d;
            rdata_q    <= rdata_d;
        end
    end

    // zero wait state; read data captured at the address phase
    assign hreadyout = 1'b1;
    assign hresp     = LTT_HRESP_OKAY;
    assign hrdata    = rdata_q;

    // trims drive the analog in every mode, not only calibration
    assign cmp0CalMode     = cmp0Trim_q[LTT_CMP_MODE_BIT];
    assign cmp0CalRefSel   = cmp0Trim_q[LTT_CMP_REF_BIT];
    assign cmp0OffsetTrim  = cmp0Trim_q[LTT_CMP_TRIM_W-1:0];
    assign cmp1CalMode     = cmp1Trim_q[LTT_CMP_MODE_BIT];
    assign cmp1CalRefSel   = cmp1Trim_q[LTT_CMP_REF_BIT];
    assign cmp1OffsetTrim  = cmp1Trim_q[LTT_CMP_TRIM_W-1:0];
    assign cmp1Hysteresis  = polHys_q[LTT_C1_HYS_LSB +: LTT_HYS_W];
    assign cmp0Hysteresis  = polHys_q[LTT_C0_HYS_LSB +: LTT_HYS_W];
    assign ampEnable       = ampEn_q;
    assign ampBandwidthSel = ampBw_q;
    assign ampCalMode      = ampTrim_q[LTT_AMP_MODE_BIT];
    assign ampCalRefSel    = ampTrim_q[LTT_AMP_REF_BIT];
    assign ampOffsetTrim   = ampTrim_q[LTT_AMP_TRIM_W-1:0];

    ltt_result_path u_result (
        .mclk            (mclk),
        .rst_n           (rst_n),
        .cmp0Raw         (cmp0Raw),
        .cmp1Raw         (cmp1Raw),
        .cmp0Invert      (polHys_q[LTT_C0_INV_BIT]),
        .cmp1Invert      (polHys_q[LTT_C1_INV_BIT]),
        .cmpOutputSelect (polHys_q[LTT_OSEL_BIT]),
        .cmp0Result      (cmp0Res),
        .cmp1Result      (cmp1Res),
        .cmpSelected     (cmpSelected)
    );
    assign cmp0Result = cmp0Res;
    assign cmp1Result = cmp1Res;

    a_cmp0_trim_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wrPend_q && addr_q == LTT_ADDR_CMP0_TRIM
        |=> cmp0OffsetTrim == $past(hwdata[4:0]) && cmp0CalMode == $past(hwdata[6]))
        else $error("cmp0 trim write not applied");
    a_cmp1_ref_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wrPend_q && addr_q == LTT_ADDR_CMP1_TRIM
        |=> cmp1CalRefSel == $past(hwdata[5]) && cmp1CalMode == $past(hwdata[6]))
        else $error("cmp1 ref write not applied");
    a_cmp0_ref_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wrPend_q && addr_q == LTT_ADDR_CMP0_TRIM |=> cmp0CalRefSel == $past(hwdata[5]))
        else $error("cmp0 ref write not applied");
    a_trim_held: assert property (@(posedge mclk) disable iff (!rst_n)
        !wrPend_q |=> $stable(cmp1OffsetTrim) && $stable(ampOffsetTrim))
        else $error("trim changed without write");
    a_hys_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wrPend_q && addr_q == LTT_ADDR_CMP_POLHY
        |=> cmp1Hysteresis == $past(hwdata[3:2]) && cmp0Hysteresis == $past(hwdata[1:0]))
        else $error("hysteresis write not applied");
    a_amp_status: assert property (@(posedge mclk) disable iff (!rst_n)
        addrPhase && !hwrite && haddr[7:0] == LTT_ADDR_AMP_CTRL
        |=> hrdata[5] == $past(ampOut_q) && hrdata[6] == $past(ampEn_q))
        else $error("amp control read wrong");
    a_amp_trim_write: assert property (@(posedge mclk) disable iff (!rst_n)
        wrPend_q && addr_q == LTT_ADDR_AMP_TRIM
        |=> ampCalMode == $past(hwdata[7]) && ampCalRefSel == $past(hwdata[6])
            && ampOffsetTrim == $past(hwdata[5:0]))
        else $error("amp trim write not applied");
    a_amp_ref_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !(wrPend_q && addr_q == LTT_ADDR_AMP_TRIM) |=> $stable(ampCalRefSel))
        else $error("amp ref changed without write");
    a_amp_trim_reset: assert property (@(posedge mclk)
        $rose(rst_n) |-> ampOffsetTrim == LTT_AMP_TRIM_RST && cmp0OffsetTrim == LTT_CMP_TRIM_RST)
        else $error("trim reset value wrong");
    a_bit7_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        addrPhase && !hwrite && haddr[7:0] != LTT_ADDR_AMP_TRIM |=> hrdata[31:7] == 25'h0)
        else $error("unimplemented bit reads nonzero");
endmodule

// ### bench/test_ltt_trim_regs.sv
/*
 * Self-checking bench for the trim register bank: reset values, field
 * masks, output fields, result conditioning and an unmapped address.
 * Assumes one AHB-Lite master (this bench) with hready fed from hreadyout.
 */
module test_ltt_trim_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ltt_pkg::*;

    logic        mclk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        cmp0Raw, cmp1Raw, ampOutRaw;
    logic        cmp0CalMode, cmp0CalRefSel, cmp0Result, cmp1CalMode, cmp1CalRefSel, cmp1Result;
    logic [4:0]  cmp0OffsetTrim, cmp1OffsetTrim;
    logic [1:0]  cmp0Hysteresis, cmp1Hysteresis;
    logic        cmpSelected, ampEnable, ampBandwidthSel, ampCalMode, ampCalRefSel;
    logic [5:0]  ampOffsetTrim;
    logic [7:0]  expReg [5];
    int          nFail, checkCount, i;

    assign hready = hreadyout;

    ltt_trim_regs uut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp0Raw(cmp0Raw),
        .cmp1Raw(cmp1Raw), .ampOutRaw(ampOutRaw), .cmp0CalMode(cmp0CalMode),
        .cmp0CalRefSel(cmp0CalRefSel), .cmp0OffsetTrim(cmp0OffsetTrim),
        .cmp0Hysteresis(cmp0Hysteresis), .cmp0Result(cmp0Result), .cmp1CalMode(cmp1CalMode),
        .cmp1CalRefSel(cmp1CalRefSel), .cmp1OffsetTrim(cmp1OffsetTrim),
        .cmp1Hysteresis(cmp1Hysteresis), .cmp1Result(cmp1Result), .cmpSelected(cmpSelected),
        .ampEnable(ampEnable), .ampBandwidthSel(ampBandwidthSel), .ampCalMode(ampCalMode),
        .ampCalRefSel(ampCalRefSel), .ampOffsetTrim(ampOffsetTrim));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] addrOf(input int k);
        case (k)
            0: return 32'(LTT_ADDR_CMP0_TRIM);
            1: return 32'(LTT_ADDR_CMP1_TRIM);
            2: return 32'(LTT_ADDR_CMP_POLHY);
            3: return 32'(LTT_ADDR_AMP_CTRL);
            4: return 32'(LTT_ADDR_AMP_TRIM);
            default: return 32'h0000_0014;
        endcase
    endfunction

    // writable bits only; status bit of the amp control is not stored
    function automatic logic [7:0] maskOf(input int k);
        case (k)
            0, 1, 2: return 8'h7f;
            3: return 8'h41;
            default: return 8'hff;
        endcase
    endfunction

    function automatic logic [31:0] expRead(input int k);
        if (k == 3) return 32'(expReg[3] | {2'h0, ampOutRaw, 5'h0});
        if (k > 4) return 32'h0;
        return 32'(expReg[k]);
    endfunction

    task automatic stopTest();
        $display("checks %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checkCount++;
        if (got !== want) begin
            nFail++;
            $display("mismatch at %0t got %h expected %h", $time, got, want);
        end
    endtask

    // address phase held until hready, then data phase held until hready
    task automatic busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= LTT_HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        do @(posedge mclk); while (hready !== 1'b1);
        rd = hrdata;
        chk(32'(hresp), 32'(LTT_HRESP_OKAY));
    endtask

    task automatic checkAll();
        @(negedge mclk);
        chk(32'({cmp0CalMode, cmp0CalRefSel, cmp0OffsetTrim}), 32'(expReg[0][6:0]));
        chk(32'({cmp1CalMode, cmp1CalRefSel, cmp1OffsetTrim}), 32'(expReg[1][6:0]));
        chk(32'({cmp1Hysteresis, cmp0Hysteresis}), 32'(expReg[2][3:0]));
        chk(32'({ampEnable, ampBandwidthSel}), 32'({expReg[3][6], expReg[3][0]}));
        chk(32'({ampCalMode, ampCalRefSel, ampOffsetTrim}), 32'(expReg[4]));
        for (int k = 0; k < 6; k++) begin
            busXfer(1'b0, addrOf(k), 32'h0);
            chk(rd, expRead(k));
        end
    endtask

    // raw results go through polarity and select one edge later
    task automatic checkResults();
        logic r0, r1;
        r0 = 1'($urandom);
        r1 = 1'($urandom);
        @(posedge mclk);
        cmp0Raw <= r0;
        cmp1Raw <= r1;
        @(posedge mclk);
        @(negedge mclk);
        chk(32'(cmp0Result), 32'(r0 ^ expReg[2][4]));
        chk(32'(cmp1Result), 32'(r1 ^ expReg[2][5]));
        chk(32'(cmpSelected), 32'(expReg[2][6] ? (r1 ^ expReg[2][5]) : (r0 ^ expReg[2][4])));
    endtask

    // software calibration sweep against a modelled comparator 0 threshold
    task automatic calSweep(input int thr);
        int t, v1, v2;
        logic first, now;
        for (int dir = 0; dir < 2; dir++) begin
            t = dir ? 31 : 0;
            for (int s = 0; s < 32; s++) begin
                busXfer(1'b1, addrOf(0), 32'h40 | 32'(t));
                @(posedge mclk);
                cmp0Raw <= (cmp0OffsetTrim >= 5'(thr));
                @(posedge mclk);
                @(negedge mclk);
                now = cmp0Result;
                if (s == 0) first = now;
                else if (now != first) break;
                t = dir ? t - 1 : t + 1;
            end
            if (dir == 0) v1 = t;
            else v2 = t;
        end
        busXfer(1'b1, addrOf(0), 32'((v1 + v2) / 2));
        expReg[0] = 8'((v1 + v2) / 2);
        @(negedge mclk);
        chk(32'(cmp0OffsetTrim), 32'((2 * thr - 1) / 2));
    endtask

    initial begin
        #100000;
        nFail++;
        stopTest();
    end

    initial begin
        {hsel, hwrite, cmp0Raw, cmp1Raw, ampOutRaw} = '0;
        haddr = '0; hwdata = '0; htrans = '0; hsize = 3'b010;
        rst_n = 1'b0;
        expReg = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h20};
        void'($urandom(32'h82fa));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        checkAll();
        // all ones then all zeros: unimplemented and read-only bits stay clear
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 6; k++) begin
                busXfer(1'b1, addrOf(k), p ? 32'h0 : 32'hffff_ffff);
                if (k < 5) expReg[k] = p ? 8'h00 : maskOf(k);
            end
            checkAll();
            checkResults();
        end
        for (int n = 0; n < 40; n++) begin
            i = int'($urandom_range(5, 0));
            @(posedge mclk);
            ampOutRaw <= 1'($urandom);
            busXfer(1'b1, addrOf(i), $urandom);
            if (i < 5) expReg[i] = hwdata[7:0] & maskOf(i);
            checkAll();
            checkResults();
        end
        calSweep(int'($urandom_range(31, 1)));
        checkAll();
        stopTest();
    end
endmodule
